/* File: hdl/can_filt_pkg.sv */
// Shared constants for the CAN acceptance mask and buffer status block
package can_filt_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS   = 3;
  localparam int NUM_RX_BUFS = 32;
  localparam int NUM_TX_BUFS = 8;
  localparam int SID_W       = 11;
  localparam int EID_W       = 18;
  localparam int FILT_NUM_W  = 5;
  localparam int BUF_NUM_W   = 5;
  localparam int TX_IDX_W    = 3;
  localparam int PTR_W       = 4;
  localparam int ADDR_W      = 12;
  localparam int HALF_W      = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_MSEL_LO  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_MSEL_HI  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_MSID0    = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_MEID0    = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_FULL_LO  = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_FULL_HI  = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_OVF_LO   = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_OVF_HI   = 12'h02c;
  localparam logic [ADDR_W-1:0] OFF_TXCTL0   = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h044;
  localparam logic [ADDR_W-1:0] REG_STRIDE   = 12'h004;

  // Mask standard register fields
  localparam int MSID_LSB = 5;
  localparam int ID_TYPE_MATCH_ENABLE_BIT = 3;
  localparam int MEID_HI_W = 2;

  // Mask source codes
  localparam logic [1:0] MSEL_RESERVED = 2'h3;

  // Buffer control byte fields
  localparam int CTL_DIR  = 7;
  localparam int CTL_ABT  = 6;
  localparam int CTL_LARB = 5;
  localparam int CTL_ERR  = 4;
  localparam int CTL_REQ  = 3;
  localparam int CTL_RTR  = 2;
  localparam int CTL_PRI  = 0;
  localparam int CTL_W    = 8;

  localparam logic [PTR_W-1:0] PTR_FIFO = 4'hf;

  // Interrupt status bits
  localparam int INT_W        = 6;
  localparam int INT_RX_STORE = 0;
  localparam int INT_RX_OVF   = 1;
  localparam int INT_RX_FIFO  = 2;
  localparam int INT_TX_DONE  = 3;
  localparam int INT_TX_ABORT = 4;
  localparam int INT_TX_ERR   = 5;

  localparam logic [HALF_W-1:0] RST_HALF = 16'h0000;
  localparam logic [31:0]       RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    TX_EVT_DONE  = 2'b00,
    TX_EVT_LOST  = 2'b01,
    TX_EVT_ERR   = 2'b10,
    TX_EVT_ABORT = 2'b11
  } tx_evt_t;
endpackage : can_filt_pkg

/* File: hdl/filter_match.sv */
// One acceptance filter compared against a received identifier
`timescale 1ns/1ps
module filter_match (
  input  wire logic [10:0] filt_sid,
  input  wire logic [17:0] filt_eid,
  input  wire logic        filt_ext,
  input  wire logic [10:0] mask_sid,
  input  wire logic [17:0] mask_eid,
  input  wire logic        mask_type,
  input  wire logic [10:0] msg_sid,
  input  wire logic [17:0] msg_eid,
  input  wire logic        msg_ext,
  output logic             hit
);
  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  // Mask one includes the bit, zero makes it don't care
  assign sid_ok  = ((msg_sid ^ filt_sid) & mask_sid) == '0;
  // Standard frames carry no extended bits to compare
  assign eid_ok  = !msg_ext || (((msg_eid ^ filt_eid) & mask_eid) == '0);
  assign type_ok = !mask_type || (filt_ext == msg_ext);
  assign hit     = sid_ok && eid_ok && type_ok;
endmodule : filter_match

/* File: hdl/can_accept_ctrl.sv */
// CAN acceptance masking, receive buffer flags and transmit buffer control
`timescale 1ns/1ps
module can_accept_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Filter settings held elsewhere
  input  wire logic [15:0] filter_enable,
  input  wire logic [10:0] filter_sid             [16],
  input  wire logic [17:0] filter_eid             [16],
  input  wire logic        filter_extended_select [16],
  input  wire logic [3:0]  filter_buffer_pointer  [16],
  // Received frame from the protocol engine
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_sid,
  input  wire logic [17:0] rx_eid,
  input  wire logic        rx_ext,
  input  wire logic        rx_rtr,
  // Store request toward the DMA buffer memory
  output logic             rx_store_valid,
  output logic             rx_store_fifo,
  output logic [4:0]       rx_store_buffer,
  output logic [4:0]       matched_filter_number,
  // Transmit engine
  input  wire logic        tx_event_valid,
  input  wire logic [2:0]  tx_event_buffer,
  input  wire logic [1:0]  tx_event_kind,
  output logic             tx_pending_valid,
  output logic [2:0]       tx_pending_buffer,
  output logic [7:0]       tx_abort_request,
  output logic             irq
);
  localparam int NF    = can_filt_pkg::NUM_FILTERS;
  localparam int NM    = can_filt_pkg::NUM_MASKS;
  localparam int NRX   = can_filt_pkg::NUM_RX_BUFS;
  localparam int NTX   = can_filt_pkg::NUM_TX_BUFS;
  localparam int SW    = can_filt_pkg::SID_W;
  localparam int EW    = can_filt_pkg::EID_W;
  localparam int HW    = can_filt_pkg::HALF_W;
  localparam int AW    = can_filt_pkg::ADDR_W;
  localparam int FNW   = can_filt_pkg::FILT_NUM_W;
  localparam int BNW   = can_filt_pkg::BUF_NUM_W;
  localparam int PW    = can_filt_pkg::PTR_W;
  localparam int TXW   = can_filt_pkg::TX_IDX_W;
  localparam int CW    = can_filt_pkg::CTL_W;
  localparam int IW    = can_filt_pkg::INT_W;
  localparam int MSELW = 2;
  localparam int PRIW  = 2;
  localparam int BPR   = HW / CW;
  localparam int NTXR  = NTX / BPR;

  // Reset release through two flip-flops
  logic [1:0] rst_sync_q;
  logic       rst_core_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync_q[1];

  // Bus decode
  logic                wr_en;
  logic                rd_setup;
  logic [HW-1:0]       wdata;
  logic                sel_msel_lo;
  logic                sel_msel_hi;
  logic                sel_full_lo;
  logic                sel_full_hi;
  logic                sel_ovf_lo;
  logic                sel_ovf_hi;
  logic                sel_int_stat;
  logic                sel_int_mask;
  wire logic [NM-1:0]  sel_msid;
  wire logic [NM-1:0]  sel_meid;
  wire logic [NTXR-1:0] sel_txctl;
  logic                addr_hit;

  assign wr_en        = psel && penable && pwrite;
  assign rd_setup     = psel && !penable && !pwrite;
  assign wdata        = pwdata[HW-1:0];
  assign sel_msel_lo  = paddr == can_filt_pkg::OFF_MSEL_LO;
  assign sel_msel_hi  = paddr == can_filt_pkg::OFF_MSEL_HI;
  assign sel_full_lo  = paddr == can_filt_pkg::OFF_FULL_LO;
  assign sel_full_hi  = paddr == can_filt_pkg::OFF_FULL_HI;
  assign sel_ovf_lo   = paddr == can_filt_pkg::OFF_OVF_LO;
  assign sel_ovf_hi   = paddr == can_filt_pkg::OFF_OVF_HI;
  assign sel_int_stat = paddr == can_filt_pkg::OFF_INT_STAT;
  assign sel_int_mask = paddr == can_filt_pkg::OFF_INT_MASK;

  for (genvar m = 0; m < NM; m++) begin : g_mdec
    localparam logic [AW-1:0] SID_ADDR = can_filt_pkg::OFF_MSID0 + AW'(m) * can_filt_pkg::REG_STRIDE;
    localparam logic [AW-1:0] EID_ADDR = can_filt_pkg::OFF_MEID0 + AW'(m) * can_filt_pkg::REG_STRIDE;
    assign sel_msid[m] = paddr == SID_ADDR;
    assign sel_meid[m] = paddr == EID_ADDR;
  end

  for (genvar t = 0; t < NTXR; t++) begin : g_tdec
    localparam logic [AW-1:0] CTL_ADDR = can_filt_pkg::OFF_TXCTL0 + AW'(t) * can_filt_pkg::REG_STRIDE;
    assign sel_txctl[t] = paddr == CTL_ADDR;
  end

  assign addr_hit = sel_msel_lo || sel_msel_hi || sel_full_lo || sel_full_hi || sel_ovf_lo
                    || sel_ovf_hi || sel_int_stat || sel_int_mask || (|sel_msid)
                    || (|sel_meid) || (|sel_txctl);

  // No wait states: every access completes in its first access cycle
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !addr_hit;

  // Mask source selection
  logic [HW-1:0]   msel_lo_q;
  logic [HW-1:0]   msel_hi_q;
  logic [2*HW-1:0] msel_all;

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      msel_lo_q <= can_filt_pkg::RST_HALF;
      msel_hi_q <= can_filt_pkg::RST_HALF;
    end else begin
      if (wr_en && sel_msel_lo) begin
        msel_lo_q <= wdata;
      end
      if (wr_en && sel_msel_hi) begin
        msel_hi_q <= wdata;
      end
    end
  end

  assign msel_all = {msel_hi_q, msel_lo_q};

  // Mask sets
  logic [SW-1:0] mask_sid_q  [NM];
  logic          mask_id_type_match_enable_q [NM];
  logic [EW-1:0] mask_eid_q  [NM];

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      for (int m = 0; m < NM; m++) begin
        mask_sid_q[m]  <= '0;
        mask_id_type_match_enable_q[m] <= 1'b0;
        mask_eid_q[m]  <= '0;
      end
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (wr_en && sel_msid[m]) begin
          mask_sid_q[m]  <= wdata[can_filt_pkg::MSID_LSB +: SW];
          mask_id_type_match_enable_q[m] <= wdata[can_filt_pkg::ID_TYPE_MATCH_ENABLE_BIT];
          mask_eid_q[m][EW-1 -: can_filt_pkg::MEID_HI_W] <= wdata[can_filt_pkg::MEID_HI_W-1:0];
        end
        if (wr_en && sel_meid[m]) begin
          mask_eid_q[m][HW-1:0] <= wdata;
        end
      end
    end
  end

  // Filter comparison
  wire logic [NF-1:0] filt_hit;

  for (genvar f = 0; f < NF; f++) begin : g_filt
    logic [MSELW-1:0] src;
    logic [MSELW-1:0] midx;
    logic             raw_hit;

    assign src  = msel_all[f*MSELW +: MSELW];
    // Reserved code never matches, so it only needs a legal index
    assign midx = (src == can_filt_pkg::MSEL_RESERVED) ? '0 : src;

    filter_match u_match (
      .filt_sid  (filter_sid[f]),
      .filt_eid  (filter_eid[f]),
      .filt_ext  (filter_extended_select[f]),
      .mask_sid  (mask_sid_q[midx]),
      .mask_eid  (mask_eid_q[midx]),
      .mask_type (mask_id_type_match_enable_q[midx]),
      .msg_sid   (rx_sid),
      .msg_eid   (rx_eid),
      .msg_ext   (rx_ext),
      .hit       (raw_hit)
    );

    assign filt_hit[f] = filter_enable[f] && (src != can_filt_pkg::MSEL_RESERVED) && raw_hit;
  end

  // Lowest numbered hitting filter wins
  logic           any_hit;
  logic [FNW-1:0] hit_num;

  always_comb begin
    any_hit = 1'b0;
    hit_num = '0;
    for (int f = NF - 1; f >= 0; f--) begin
      if (filt_hit[f]) begin
        any_hit = 1'b1;
        hit_num = FNW'(f);
      end
    end
  end

  // Destination of an accepted frame
  wire logic [NTX-1:0]          ctl_dir;
  wire logic [NTX-1:0]          ctl_rtr;
  wire logic [NTX-1:0]          ctl_req;
  wire logic [NTX-1:0]          abort_req;
  wire logic [NTX-1:0][PRIW-1:0] ctl_pri;
  wire logic [NTX-1:0][CW-1:0]  ctl_byte;
  logic [NRX-1:0]               full_q;
  logic [NRX-1:0]               ovf_q;
  logic [PW-1:0]                hit_ptr;
  logic                         to_fifo;
  logic [TXW-1:0]               tx_sel;
  logic [BNW-1:0]               buf_idx;
  logic                         to_tx_buf;
  logic                         rx_take;
  logic                         rx_store;
  logic                         rx_overflow;
  logic                         rtr_reply;

  assign hit_ptr   = filter_buffer_pointer[hit_num[PW-1:0]];
  assign to_fifo   = hit_ptr == can_filt_pkg::PTR_FIFO;
  assign buf_idx   = BNW'(hit_ptr);
  assign tx_sel    = hit_ptr[TXW-1:0];
  assign to_tx_buf = !to_fifo && (hit_ptr < PW'(NTX)) && ctl_dir[tx_sel];
  assign rx_take   = rx_valid && any_hit;
  // A transmit buffer never takes received data, it may only answer a remote frame
  assign rtr_reply   = rx_take && to_tx_buf && rx_rtr && ctl_rtr[tx_sel];
  assign rx_store    = rx_take && !to_tx_buf && (to_fifo || !full_q[buf_idx]);
  assign rx_overflow = rx_take && !to_tx_buf && !to_fifo && full_q[buf_idx];

  // Store request; the message itself goes to buffer memory
  logic           store_valid_q;
  logic           store_fifo_q;
  logic [BNW-1:0] store_buf_q;
  logic [FNW-1:0] store_filt_q;

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      store_valid_q <= 1'b0;
      store_fifo_q  <= 1'b0;
      store_buf_q   <= '0;
      store_filt_q  <= '0;
    end else begin
      store_valid_q <= rx_store;
      if (rx_store) begin
        store_fifo_q <= to_fifo;
        store_buf_q  <= buf_idx;
        store_filt_q <= hit_num;
      end
    end
  end

  assign rx_store_valid        = store_valid_q;
  assign rx_store_fifo         = store_fifo_q;
  assign rx_store_buffer       = store_buf_q;
  assign matched_filter_number = store_filt_q;

  // Full and overflow flags
  logic [NRX-1:0] full_set;
  logic [NRX-1:0] ovf_set;
  logic [NRX-1:0] full_keep;
  logic [NRX-1:0] ovf_keep;

  always_comb begin
    full_set = '0;
    ovf_set  = '0;
    if (rx_store && !to_fifo) begin
      full_set[buf_idx] = 1'b1;
    end
    if (rx_overflow) begin
      ovf_set[buf_idx] = 1'b1;
    end
  end

  always_comb begin
    full_keep = '1;
    ovf_keep  = '1;
    if (wr_en && sel_full_lo) begin
      full_keep[HW-1:0] = wdata;
    end
    if (wr_en && sel_full_hi) begin
      full_keep[NRX-1:HW] = wdata;
    end
    if (wr_en && sel_ovf_lo) begin
      ovf_keep[HW-1:0] = wdata;
    end
    if (wr_en && sel_ovf_hi) begin
      ovf_keep[NRX-1:HW] = wdata;
    end
  end

  // A store in the same cycle as a clear wins
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      full_q <= '0;
      ovf_q  <= '0;
    end else begin
      full_q <= (full_q & full_keep) | full_set;
      ovf_q  <= (ovf_q & ovf_keep) | ovf_set;
    end
  end

  // Transmit event decode
  can_filt_pkg::tx_evt_t evt_kind;
  logic                  evt_done;
  logic                  evt_abort;
  logic                  evt_err;

  assign evt_kind  = can_filt_pkg::tx_evt_t'(tx_event_kind);
  assign evt_done  = tx_event_valid && (evt_kind == can_filt_pkg::TX_EVT_DONE);
  assign evt_abort = tx_event_valid && (evt_kind == can_filt_pkg::TX_EVT_ABORT);
  assign evt_err   = tx_event_valid && (evt_kind == can_filt_pkg::TX_EVT_ERR);

  // Buffer control bytes, two buffers per word, even buffer in the low byte
  for (genvar b = 0; b < NTX; b++) begin : g_tx
    logic            dir_q;
    logic            abt_q;
    logic            larb_q;
    logic            err_q;
    logic            req_q;
    logic            rtr_q;
    logic [PRIW-1:0] pri_q;
    logic            abort_q;
    logic            wr_hit;
    logic [CW-1:0]   wbyte;
    logic            evt_hit;
    logic            req_set;
    logic            req_end;

    assign wr_hit  = wr_en && sel_txctl[b / BPR];
    assign wbyte   = wdata[(b % BPR) * CW +: CW];
    assign evt_hit = tx_event_valid && (tx_event_buffer == TXW'(b));
    assign req_end = evt_hit && (evt_done || evt_abort);
    assign req_set = !req_q && ((wr_hit && wbyte[can_filt_pkg::CTL_REQ])
                     || (rtr_reply && (tx_sel == TXW'(b))));

    always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        dir_q <= 1'b0;
        rtr_q <= 1'b0;
        pri_q <= '0;
      end else if (wr_hit) begin
        dir_q <= wbyte[can_filt_pkg::CTL_DIR];
        rtr_q <= wbyte[can_filt_pkg::CTL_RTR];
        pri_q <= wbyte[can_filt_pkg::CTL_PRI +: PRIW];
      end
    end

    // Software writing zero does not drop the request, it asks for an abort
    always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        req_q <= 1'b0;
      end else if (req_end) begin
        req_q <= 1'b0;
      end else if (req_set) begin
        req_q <= 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        abort_q <= 1'b0;
      end else if (req_end) begin
        abort_q <= 1'b0;
      end else if (wr_hit && !wbyte[can_filt_pkg::CTL_REQ] && req_q) begin
        abort_q <= 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        abt_q  <= 1'b0;
        larb_q <= 1'b0;
        err_q  <= 1'b0;
      end else if (req_set) begin
        abt_q  <= 1'b0;
        larb_q <= 1'b0;
        err_q  <= 1'b0;
      end else if (evt_hit) begin
        unique case (evt_kind)
          can_filt_pkg::TX_EVT_DONE:  abt_q  <= 1'b0;
          can_filt_pkg::TX_EVT_LOST:  larb_q <= 1'b1;
          can_filt_pkg::TX_EVT_ERR:   err_q  <= 1'b1;
          can_filt_pkg::TX_EVT_ABORT: abt_q  <= 1'b1;
        endcase
      end
    end

    assign ctl_dir[b]   = dir_q;
    assign ctl_rtr[b]   = rtr_q;
    assign ctl_req[b]   = req_q;
    assign ctl_pri[b]   = pri_q;
    assign abort_req[b] = abort_q;
    assign ctl_byte[b]  = {dir_q, abt_q, larb_q, err_q, req_q, rtr_q, pri_q};
  end

  assign tx_abort_request = abort_req;

  // Pending selection; on equal priority the higher buffer number goes first
  logic            pend_any;
  logic [TXW-1:0]  pend_idx;
  logic [PRIW-1:0] pend_pri;
  logic            pend_valid_q;
  logic [TXW-1:0]  pend_buf_q;

  always_comb begin
    pend_any = 1'b0;
    pend_idx = '0;
    pend_pri = '0;
    for (int b = 0; b < NTX; b++) begin
      if (ctl_dir[b] && ctl_req[b] && !abort_req[b] && (!pend_any || ctl_pri[b] >= pend_pri)) begin
        pend_any = 1'b1;
        pend_idx = TXW'(b);
        pend_pri = ctl_pri[b];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pend_valid_q <= 1'b0;
      pend_buf_q   <= '0;
    end else begin
      pend_valid_q <= pend_any;
      pend_buf_q   <= pend_idx;
    end
  end

  assign tx_pending_valid  = pend_valid_q;
  assign tx_pending_buffer = pend_buf_q;

  // Interrupt status, sticky and cleared by writing one
  logic [IW-1:0] int_stat_q;
  logic [IW-1:0] int_mask_q;
  logic [IW-1:0] int_evt;
  logic [IW-1:0] int_clr;

  always_comb begin
    int_evt = '0;
    int_evt[can_filt_pkg::INT_RX_STORE] = rx_store;
    int_evt[can_filt_pkg::INT_RX_OVF]   = rx_overflow;
    int_evt[can_filt_pkg::INT_RX_FIFO]  = rx_store && to_fifo;
    int_evt[can_filt_pkg::INT_TX_DONE]  = evt_done;
    int_evt[can_filt_pkg::INT_TX_ABORT] = evt_abort;
    int_evt[can_filt_pkg::INT_TX_ERR]   = evt_err;
  end

  assign int_clr = (wr_en && sel_int_stat) ? wdata[IW-1:0] : '0;

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | int_evt;
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      int_mask_q <= '0;
    end else if (wr_en && sel_int_mask) begin
      int_mask_q <= wdata[IW-1:0];
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // Read data, captured in the setup cycle so it stands through the access
  logic [HW-1:0]   rd_half;
  logic [2*HW-1:0] prdata_q;

  always_comb begin
    rd_half = '0;
    if (sel_msel_lo) begin
      rd_half = msel_lo_q;
    end
    if (sel_msel_hi) begin
      rd_half = msel_hi_q;
    end
    for (int m = 0; m < NM; m++) begin
      if (sel_msid[m]) begin
        rd_half = {mask_sid_q[m], 1'b0, mask_id_type_match_enable_q[m], 1'b0,
                   mask_eid_q[m][EW-1 -: can_filt_pkg::MEID_HI_W]};
      end
      if (sel_meid[m]) begin
        rd_half = mask_eid_q[m][HW-1:0];
      end
    end
    if (sel_full_lo) begin
      rd_half = full_q[HW-1:0];
    end
    if (sel_full_hi) begin
      rd_half = full_q[NRX-1:HW];
    end
    if (sel_ovf_lo) begin
      rd_half = ovf_q[HW-1:0];
    end
    if (sel_ovf_hi) begin
      rd_half = ovf_q[NRX-1:HW];
    end
    for (int t = 0; t < NTXR; t++) begin
      if (sel_txctl[t]) begin
        rd_half = {ctl_byte[t*BPR+1], ctl_byte[t*BPR]};
      end
    end
    if (sel_int_stat) begin
      rd_half = HW'(int_stat_q);
    end
    if (sel_int_mask) begin
      rd_half = HW'(int_mask_q);
    end
  end

  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      prdata_q <= can_filt_pkg::RST_WORD;
    end else if (rd_setup) begin
      prdata_q <= {{HW{1'b0}}, rd_half};
    end
  end

  assign prdata = prdata_q;

endmodule : can_accept_ctrl

/* File: verif/can_accept_ctrl_assertions.sv */
// Port checker for the acceptance block
`timescale 1ns/1ps
module can_accept_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        irq,
  input wire logic        rx_valid,
  input wire logic        tx_event_valid,
  input wire logic        rx_store_valid,
  input wire logic        rx_store_fifo,
  input wire logic [31:0] prdata,
  input wire logic [4:0]  rx_store_buffer,
  input wire logic [4:0]  matched_filter_number,
  input wire logic [7:0]  tx_abort_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire s = rx_store_valid;
  wire w = psel && pwrite;
  wire e = rx_valid || tx_event_valid || w;
  property p_hi; psel && penable && pready && !pwrite |-> !prdata[31:16]; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
  property p_fn; s |-> matched_filter_number < 5'h10; endproperty
  a_fn: assert property (p_fn) else $error("filter number");
  property p_bp; s && !rx_store_fifo |-> rx_store_buffer < 5'h0f; endproperty
  a_bp: assert property (p_bp) else $error("buffer number");
  property p_src; s |-> rx_valid || $past(rx_valid) || $past(rx_valid, 2); endproperty
  a_src: assert property (p_src) else $error("no frame");
  property p_idl; !rx_valid [*4] |-> !s; endproperty
  a_idl: assert property (p_idl) else $error("stray store");
  property p_ab; $rose(|tx_abort_request) |-> $past(w) || $past(w, 2); endproperty
  a_ab: assert property (p_ab) else $error("stray abort");
  property p_fl; $fell(irq) |-> $past(w) || $past(w, 2); endproperty
  a_fl: assert property (p_fl) else $error("irq fell");
  property p_rs; $rose(irq) |-> $past(e) || $past(e, 2) || $past(e, 3); endproperty
  a_rs: assert property (p_rs) else $error("irq rose");
endmodule : can_accept_chk
bind can_accept_ctrl can_accept_chk u_chk (.*);

/* File: verif/can_node_model.sv */
// Stand-in for the other bus nodes delivering frames
`timescale 1ns/1ps
module can_node_model (input wire logic clk, output logic rx_valid = 1'b0, rx_ext = 1'b0,
  rx_rtr = 1'b0, tx_event_valid = 1'b0, output logic [10:0] rx_sid = 11'h0,
  output logic [17:0] rx_eid = 18'h0, output logic [2:0] tx_event_buffer = 3'h0,
  output logic [1:0] tx_event_kind = 2'h0);
  // Id inverted outside frames so a stale value cannot match
  task automatic send(input logic [10:0] id, input logic rtr = 1'b0);
    @(posedge clk) {rx_valid, rx_rtr, rx_sid} <= {1'b1, rtr, id};
    @(posedge clk) {rx_valid, rx_rtr, rx_sid} <= {1'b0, 1'b0, ~id};
  endtask : send
  // Transmit engine outcome for one buffer
  task automatic tx(input logic [2:0] b, input logic [1:0] k);
    @(posedge clk) {tx_event_valid, tx_event_buffer, tx_event_kind} <= {1'b1, b, k};
    @(posedge clk) tx_event_valid <= 1'b0;
  endtask : tx
endmodule : can_node_model

/* File: verif/tb.sv */
// Bench for the acceptance block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic irq, rx_valid, rx_ext, rx_rtr, rx_store_valid, rx_store_fifo, tx_event_valid;
  logic tx_pending_valid, filter_extended_select [16] = '{default: 1'b0};
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] filter_enable = 16'h0001;
  logic [11:0] paddr = 12'h0;
  logic [10:0] rx_sid, filter_sid [16] = '{default: 11'h123};
  logic [17:0] rx_eid, filter_eid [16] = '{default: 18'h0};
  logic [4:0] rx_store_buffer, matched_filter_number, sbuf = 5'h0;
  logic se = 1'b0;
  logic [3:0] filter_buffer_pointer [16] = '{default: 4'h3};
  logic [2:0] tx_event_buffer, tx_pending_buffer;
  logic [1:0] tx_event_kind;
  logic [7:0] tx_abort_request;
  int miscompares = 0, checks_done = 0, nst = 0;
  initial forever #2 clk = ~clk;
  can_node_model node (.*);
  can_accept_ctrl dut (.*);
  always @(posedge clk) if (rx_store_valid === 1'b1) begin nst <= nst + 1; sbuf <= rx_store_buffer; end
  task automatic chk(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin miscompares++; $display("[ERR] %0t got %h want %h", $time, g, x); end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rx(input logic [10:0] id, input int n);
    node.send(id);
    repeat (6) @(posedge clk);
    if (n >= 0) chk(nst, n);
  endtask : rx
  task automatic t_regs;
    for (int i = 0; i < 16; i += 4) begin apb(1'b0, 12'h020 + 12'(i), 32'h0); chk(rd, 32'h0); end
    apb(1'b1, 12'h000, 32'hffffaaaa);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'haaaa);
    apb(1'b0, 12'h0fc, 32'h0); chk({se, rd}, {1'b1, 32'h0});
    apb(1'b1, 12'h000, 32'h0);
  endtask : t_regs
  task automatic t_rx;
    apb(1'b1, 12'h008, 32'hffe0);
    rx(11'h123, 1);
    chk(sbuf, 32'h3);
    rx(11'h124, 1);
    apb(1'b1, 12'h020, 32'hffff);
    apb(1'b0, 12'h020, 32'h0); chk(rd, 32'h8);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b0, 12'h020, 32'h0); chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    rx(11'h124, 2);
    rx(11'h124, -1);
    apb(1'b0, 12'h028, 32'h0); chk(rd, 32'h8);
  endtask : t_rx
  task automatic t_tx;
    apb(1'b1, 12'h044, 32'h10);
    apb(1'b1, 12'h030, 32'h8a8b);
    repeat (2) @(posedge clk);
    chk({tx_pending_valid, tx_pending_buffer}, 32'h8);
    node.tx(3'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk({tx_pending_valid, tx_pending_buffer}, 32'h9);
    apb(1'b0, 12'h030, 32'h0); chk(rd, 32'h8a83);
    apb(1'b1, 12'h030, 32'h8283);
    @(posedge clk);
    chk(tx_abort_request, 32'h2);
    chk(irq, 32'h0);
    node.tx(3'h1, 2'h3);
    repeat (2) @(posedge clk);
    chk({irq, tx_abort_request}, 32'h100);
    apb(1'b0, 12'h030, 32'h0); chk(rd, 32'hc283);
    apb(1'b1, 12'h040, 32'h3f);
    @(posedge clk);
    chk(irq, 32'h0);
    apb(1'b1, 12'h034, 32'h8400);
    node.send(11'h123, 1'b1);
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h034, 32'h0); chk(rd, 32'h8c00);
    chk({tx_pending_valid, tx_pending_buffer}, 32'hb);
  endtask : t_tx
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_rx();
    t_tx();
    summarize();
  end
  initial begin #40000 miscompares++; summarize(); end
endmodule : tb
